// File: hdl/mac_seq_pkg.sv
package mac_seq_pkg;
    // medium timing; the gap figure is a plain default, override per PHY
    localparam int CLK_NS = 10;
    localparam int SIFS_NS = 160;
    localparam int SIFS_CYCLES = (SIFS_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_W = 8;
    localparam logic [GAP_W-1:0] GAP_SIFS = GAP_W'(SIFS_CYCLES);
    localparam logic [GAP_W-1:0] GAP_RESET = 8'hFF;

    // frame count limits per sequence
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] BC_MAX = 5'h0A;
    localparam logic [CNT_W-1:0] DIR_MAX = 5'h16;
    localparam logic [CNT_W-1:0] PS_MAX = 5'h15;
    localparam logic [CNT_W-1:0] CF_MGMT_MAX = 5'h0B;
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;

    typedef enum logic [3:0] {
        K_DATA = 4'h0,
        K_DATA_POLL = 4'h1,
        K_DATA_POLL_ACK = 4'h2,
        K_DATA_CFACK = 4'h3,
        K_CFACK = 4'h4,
        K_POLL = 4'h5,
        K_POLL_ACK = 4'h6,
        K_NULL = 4'h7,
        K_MGMT = 4'h8,
        K_BEACON = 4'h9,
        K_RTS = 4'hA,
        K_CTS = 4'hB,
        K_ACK = 4'hC,
        K_PSPOLL = 4'hD,
        K_CFEND = 4'hE,
        K_CFEND_ACK = 4'hF
    } frame_kind_t;

    // one frame on the medium, as seen after reception
    typedef struct packed {
        frame_kind_t kind;
        logic addr1_group;
        logic da_group;
        logic cf_dur_nz;
    } frame_t;

    localparam frame_t FRAME_RESET = '{kind: K_ACK, addr1_group: 1'b0, da_group: 1'b0,
                                       cf_dur_nz: 1'b0};
endpackage

// File: hdl/mac_medium_if.sv
`timescale 1ns/10ps
interface mac_medium_if (
    input wire logic ref_clk_in,
    input wire logic rst_n_in
);
    logic coord_valid;
    mac_seq_pkg::frame_t coord_frame;
    logic sta_valid;
    mac_seq_pkg::frame_t sta_frame;

    modport coordinator (
        input ref_clk_in,
        input rst_n_in,
        output coord_valid,
        output coord_frame,
        input sta_valid,
        input sta_frame
    );

    modport station (
        input ref_clk_in,
        input rst_n_in,
        input coord_valid,
        input coord_frame,
        output sta_valid,
        output sta_frame
    );
endinterface

// File: hdl/mac_station_end.sv
`timescale 1ns/10ps
module mac_station_end (
    mac_medium_if.station med,
    input wire logic queue_nonempty_in,
    input wire logic cf_aware_in,
    output logic data_taken_out,
    output logic cf_active_out
);
    typedef struct packed {
        logic [mac_seq_pkg::GAP_W-1:0] gap;
        logic cf_active;
        logic resp_pend;
        mac_seq_pkg::frame_t resp;
        logic tx_valid;
        mac_seq_pkg::frame_t tx_frame;
        logic taken;
    } sta_state_t;

    sta_state_t st;
    sta_state_t next_st;
    logic any_valid;
    mac_seq_pkg::frame_t rx;
    logic rx_dir;

    assign any_valid = med.coord_valid | med.sta_valid;
    assign rx = med.coord_frame;
    assign rx_dir = ~rx.addr1_group;

    // a reply is decided when the frame lands and sent one gap later
    always_comb begin
        next_st = st;
        next_st.tx_valid = 1'b0;
        next_st.taken = 1'b0;
        if (any_valid) begin
            next_st.gap = '0;
        end else if (st.gap != mac_seq_pkg::GAP_RESET) begin
            next_st.gap = st.gap + 1'b1;
        end
        if (st.resp_pend && !any_valid && st.gap == mac_seq_pkg::GAP_SIFS - 1'b1) begin
            next_st.tx_valid = 1'b1;
            next_st.tx_frame = st.resp;
            next_st.resp_pend = 1'b0;
            next_st.taken = (st.resp.kind == mac_seq_pkg::K_DATA_CFACK)
                || (st.resp.kind == mac_seq_pkg::K_DATA);
        end
        if (med.coord_valid) begin
            next_st.resp_pend = 1'b0;
            next_st.resp = mac_seq_pkg::FRAME_RESET;
            if (rx.kind == mac_seq_pkg::K_BEACON) begin
                next_st.cf_active = rx.cf_dur_nz;
            end
            if (rx.kind == mac_seq_pkg::K_CFEND || rx.kind == mac_seq_pkg::K_CFEND_ACK) begin
                next_st.cf_active = 1'b0;
            end
            unique case (rx.kind)
                mac_seq_pkg::K_DATA_POLL, mac_seq_pkg::K_DATA_POLL_ACK: begin
                    if (rx_dir) begin
                        next_st.resp_pend = 1'b1;
                        if (!cf_aware_in) begin
                            next_st.resp.kind = mac_seq_pkg::K_ACK;
                        end else if (queue_nonempty_in) begin
                            next_st.resp.kind = mac_seq_pkg::K_DATA_CFACK;
                        end else begin
                            next_st.resp.kind = mac_seq_pkg::K_CFACK;
                        end
                    end
                end
                mac_seq_pkg::K_POLL, mac_seq_pkg::K_POLL_ACK: begin
                    next_st.resp_pend = 1'b1;
                    next_st.resp.kind = queue_nonempty_in ? mac_seq_pkg::K_DATA
                                                          : mac_seq_pkg::K_NULL;
                end
                mac_seq_pkg::K_DATA, mac_seq_pkg::K_DATA_CFACK, mac_seq_pkg::K_MGMT: begin
                    next_st.resp_pend = rx_dir;
                    if (rx.kind == mac_seq_pkg::K_MGMT) begin
                        next_st.resp_pend = !rx.da_group;
                    end
                    next_st.resp.kind = mac_seq_pkg::K_ACK;
                end
                mac_seq_pkg::K_RTS: begin
                    next_st.resp_pend = 1'b1;
                    next_st.resp.kind = mac_seq_pkg::K_CTS;
                end
                default: begin
                    next_st.resp_pend = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge med.ref_clk_in or negedge med.rst_n_in) begin
        if (!med.rst_n_in) begin
            st <= '{gap: mac_seq_pkg::GAP_RESET, cf_active: 1'b0, resp_pend: 1'b0,
                    resp: mac_seq_pkg::FRAME_RESET, tx_valid: 1'b0,
                    tx_frame: mac_seq_pkg::FRAME_RESET, taken: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign med.sta_valid = st.tx_valid;
    assign med.sta_frame = st.tx_frame;
    assign data_taken_out = st.taken;
    assign cf_active_out = st.cf_active;
endmodule

// File: hdl/mac_coord_end.sv
`timescale 1ns/10ps
module mac_coord_end (
    mac_medium_if.coordinator med,
    input wire logic tx_valid_in,
    input wire mac_seq_pkg::frame_t tx_frame_in,
    output logic tx_ready_out,
    input wire logic cf_end_req_in,
    output logic cf_end_ready_out,
    output logic protocol_error_out,
    output logic cf_active_out,
    output logic frame_seen_out
);
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_CP_RTS = 4'h1,
        S_CP_CTS = 4'h3,
        S_CP_ACKW = 4'h2,
        S_CP_DONE = 4'h6,
        S_CP_BC = 4'h7,
        S_PS_POLL = 4'h5,
        S_PS_END = 4'h4,
        S_CF_IDLE = 4'hC,
        S_CF_BC = 4'hD,
        S_CF_BCM = 4'hF,
        S_CF_CFACK = 4'hE,
        S_CF_POLLD = 4'hA,
        S_CF_REPLY = 4'hB,
        S_CF_POLLN = 4'h9,
        S_CF_ACKW = 4'h8
    } seq_state_t;

    typedef struct packed {
        seq_state_t seq;
        logic [mac_seq_pkg::CNT_W-1:0] cnt;
        logic [mac_seq_pkg::CNT_W-1:0] limit;
        logic [mac_seq_pkg::GAP_W-1:0] gap;
        logic cf_active;
        logic owe_ack;
        logic tx_pend;
        logic end_pend;
        mac_seq_pkg::frame_t pend_frame;
        logic out_valid;
        mac_seq_pkg::frame_t out_frame;
        logic err;
        logic seen;
    } coord_state_t;

    coord_state_t st;
    coord_state_t next_st;
    logic obs_valid;
    mac_seq_pkg::frame_t f;
    logic f_group;
    logic f_data;
    logic f_mgmt;
    logic f_dir_dm;
    logic [mac_seq_pkg::CNT_W-1:0] cnt_inc;

    assign obs_valid = med.coord_valid | med.sta_valid;
    assign f = med.coord_valid ? med.coord_frame : med.sta_frame;
    assign f_data = f.kind == mac_seq_pkg::K_DATA || f.kind == mac_seq_pkg::K_DATA_POLL
        || f.kind == mac_seq_pkg::K_DATA_POLL_ACK || f.kind == mac_seq_pkg::K_DATA_CFACK;
    assign f_mgmt = f.kind == mac_seq_pkg::K_MGMT || f.kind == mac_seq_pkg::K_BEACON;
    // data classes by first address, management by destination address
    assign f_group = f_mgmt ? f.da_group : f.addr1_group;
    assign f_dir_dm = (f_data || f_mgmt) && !f_group;
    assign cnt_inc = st.cnt + 1'b1;

    // start of a free-period sub-sequence; any of them may follow any other
    function automatic seq_state_t cf_start(input mac_seq_pkg::frame_t fr, input logic grp,
                                            input logic isdata, input logic ismgmt);
        seq_state_t s;
        s = S_IDLE;
        if (isdata && grp && fr.kind == mac_seq_pkg::K_DATA) begin
            s = S_CF_BC;
        end else if (ismgmt && grp) begin
            s = S_CF_BCM;
        end else if (fr.kind == mac_seq_pkg::K_CFACK) begin
            s = S_CF_CFACK;
        end else if (!grp && (fr.kind == mac_seq_pkg::K_DATA_POLL
                              || fr.kind == mac_seq_pkg::K_DATA_POLL_ACK)) begin
            s = S_CF_POLLD;
        end else if (fr.kind == mac_seq_pkg::K_POLL || fr.kind == mac_seq_pkg::K_POLL_ACK) begin
            s = S_CF_POLLN;
        end else if (!grp && (fr.kind == mac_seq_pkg::K_DATA
                              || fr.kind == mac_seq_pkg::K_DATA_CFACK)) begin
            s = S_CF_ACKW;
        end else if (fr.kind == mac_seq_pkg::K_CFEND || fr.kind == mac_seq_pkg::K_CFEND_ACK) begin
            s = S_CF_IDLE;
        end
        return s;
    endfunction

    // states where the sequence may legally stop
    function automatic logic may_end(input seq_state_t s);
        return s == S_IDLE || s == S_CP_BC || s == S_CP_DONE || s == S_PS_END
            || s == S_CF_IDLE || s == S_CF_BC || s == S_CF_BCM || s == S_CF_REPLY;
    endfunction

    always_comb begin
        seq_state_t base;
        seq_state_t cs;
        logic bad;
        logic boundary;
        base = S_IDLE;
        cs = S_IDLE;
        bad = 1'b0;
        boundary = 1'b0;
        next_st = st;
        next_st.out_valid = 1'b0;
        next_st.err = 1'b0;
        next_st.seen = obs_valid;
        if (obs_valid) begin
            next_st.gap = '0;
        end else if (st.gap != mac_seq_pkg::GAP_RESET) begin
            next_st.gap = st.gap + 1'b1;
        end
        // user requests; a frame goes no sooner than one gap after the last,
        // and at once when the medium has been idle longer than that
        if (tx_valid_in && !st.tx_pend) begin
            next_st.tx_pend = 1'b1;
            next_st.pend_frame = tx_frame_in;
        end
        if (cf_end_req_in && !st.end_pend && st.cf_active) begin
            next_st.end_pend = 1'b1;
        end
        if (!obs_valid && st.gap >= mac_seq_pkg::GAP_SIFS - 1'b1) begin
            if (st.end_pend) begin
                next_st.end_pend = 1'b0;
                next_st.out_valid = 1'b1;
                next_st.out_frame = mac_seq_pkg::FRAME_RESET;
                next_st.out_frame.kind = st.owe_ack ? mac_seq_pkg::K_CFEND_ACK
                                                    : mac_seq_pkg::K_CFEND;
                next_st.out_frame.addr1_group = 1'b1;
            end else if (st.tx_pend) begin
                next_st.tx_pend = 1'b0;
                next_st.out_valid = 1'b1;
                next_st.out_frame = st.pend_frame;
            end
        end
        // sequence checking over every frame on the medium
        if (obs_valid) begin
            if (med.coord_valid && med.sta_valid) begin
                bad = 1'b1;
            end
            if (st.gap < mac_seq_pkg::GAP_SIFS) begin
                bad = 1'b1;
            end
            boundary = st.gap > mac_seq_pkg::GAP_SIFS;
            if (boundary && !may_end(st.seq)) begin
                bad = 1'b1;
            end
            base = st.seq;
            if (boundary || st.seq == S_PS_END || st.seq == S_CP_DONE && !f_dir_dm) begin
                base = st.cf_active ? S_CF_IDLE : S_IDLE;
            end
            if (st.seq == S_CP_DONE && !boundary && !f_dir_dm) begin
                bad = 1'b1;
            end
            if (st.seq == S_PS_END && !boundary) begin
                bad = 1'b1;
            end
            // broadcast and reply runs fall back to a fresh sub-sequence
            if (st.cf_active && !boundary && (st.seq == S_CF_BC && !(f_data && f_group)
                || st.seq == S_CF_BCM && !(f_mgmt && f_group)
                || st.seq == S_CF_REPLY && f.kind != mac_seq_pkg::K_ACK)) begin
                base = S_CF_IDLE;
            end
            next_st.seq = base;
            next_st.cnt = cnt_inc;
            unique case (base)
                S_IDLE, S_PS_END: begin
                    next_st.cnt = 5'h01;
                    next_st.limit = mac_seq_pkg::DIR_MAX;
                    if (f.kind == mac_seq_pkg::K_BEACON && f.cf_dur_nz) begin
                        next_st.seq = S_CF_IDLE;
                        next_st.cf_active = 1'b1;
                    end else if ((f_data && f.kind == mac_seq_pkg::K_DATA || f_mgmt) && f_group) begin
                        next_st.seq = S_CP_BC;
                        next_st.limit = mac_seq_pkg::BC_MAX;
                    end else if (f_dir_dm && f.kind == mac_seq_pkg::K_DATA
                                 || f_dir_dm && f.kind == mac_seq_pkg::K_MGMT) begin
                        next_st.seq = S_CP_ACKW;
                    end else if (f.kind == mac_seq_pkg::K_RTS) begin
                        next_st.seq = S_CP_RTS;
                    end else if (f.kind == mac_seq_pkg::K_PSPOLL) begin
                        next_st.seq = S_PS_POLL;
                        next_st.limit = mac_seq_pkg::PS_MAX;
                    end else begin
                        bad = 1'b1;
                    end
                end
                S_CP_BC: begin
                    bad = !(f_group && (f_data || f_mgmt)) || cnt_inc > st.limit;
                end
                S_CP_RTS: begin
                    next_st.seq = S_CP_CTS;
                    bad = f.kind != mac_seq_pkg::K_CTS;
                end
                S_CP_CTS, S_CP_DONE: begin
                    next_st.seq = S_CP_ACKW;
                    bad = !f_dir_dm;
                end
                S_CP_ACKW: begin
                    next_st.seq = S_CP_DONE;
                    bad = f.kind != mac_seq_pkg::K_ACK || cnt_inc > st.limit;
                end
                S_PS_POLL: begin
                    next_st.seq = (f.kind == mac_seq_pkg::K_ACK) ? S_PS_END : S_CP_ACKW;
                    bad = f.kind != mac_seq_pkg::K_ACK && !(f_dir_dm && f_data);
                end
                S_CF_IDLE: begin
                    cs = cf_start(f, f_group, f_data, f_mgmt);
                    next_st.seq = cs;
                    next_st.cnt = 5'h01;
                    next_st.limit = (cs == S_CF_BC) ? mac_seq_pkg::BC_MAX
                                                    : mac_seq_pkg::CF_MGMT_MAX;
                    bad = cs == S_IDLE;
                    if (f.kind == mac_seq_pkg::K_CFEND || f.kind == mac_seq_pkg::K_CFEND_ACK) begin
                        next_st.seq = S_IDLE;
                        next_st.cf_active = 1'b0;
                        if ((f.kind == mac_seq_pkg::K_CFEND_ACK) != st.owe_ack) begin
                            bad = 1'b1;
                        end
                    end
                end
                S_CF_BC, S_CF_BCM: begin
                    bad = cnt_inc > st.limit;
                end
                S_CF_CFACK: begin
                    next_st.seq = S_CF_BCM;
                    bad = !(f_mgmt && f_group);
                end
                S_CF_POLLD: begin
                    next_st.seq = (f.kind == mac_seq_pkg::K_DATA_CFACK) ? S_CF_REPLY : S_CF_IDLE;
                    bad = !(f.kind == mac_seq_pkg::K_DATA_CFACK && !f_group
                            || f.kind == mac_seq_pkg::K_CFACK
                            || f.kind == mac_seq_pkg::K_ACK);
                end
                S_CF_REPLY, S_CF_ACKW: begin
                    next_st.seq = S_CF_IDLE;
                    bad = f.kind != mac_seq_pkg::K_ACK;
                end
                S_CF_POLLN: begin
                    next_st.seq = (f.kind == mac_seq_pkg::K_DATA) ? S_CF_REPLY : S_CF_IDLE;
                    bad = !(f.kind == mac_seq_pkg::K_DATA && !f_group
                            || f.kind == mac_seq_pkg::K_NULL);
                end
            endcase
            // the end frame owes an ack when a station's directed data or management frame came last
            next_st.owe_ack = med.sta_valid && f_dir_dm && f.kind != mac_seq_pkg::K_NULL;
            if (bad) begin
                next_st.err = 1'b1;
                next_st.seq = st.cf_active ? S_CF_IDLE : S_IDLE;
                next_st.cnt = mac_seq_pkg::CNT_RESET;
            end
        end
    end

    always_ff @(posedge med.ref_clk_in or negedge med.rst_n_in) begin
        if (!med.rst_n_in) begin
            st <= '{seq: S_IDLE, cnt: mac_seq_pkg::CNT_RESET, limit: mac_seq_pkg::CNT_RESET,
                    gap: mac_seq_pkg::GAP_RESET, cf_active: 1'b0, owe_ack: 1'b0,
                    tx_pend: 1'b0, end_pend: 1'b0, pend_frame: mac_seq_pkg::FRAME_RESET,
                    out_valid: 1'b0, out_frame: mac_seq_pkg::FRAME_RESET, err: 1'b0,
                    seen: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign med.coord_valid = st.out_valid;
    assign med.coord_frame = st.out_frame;
    assign tx_ready_out = !st.tx_pend;
    assign cf_end_ready_out = !st.end_pend && st.cf_active;
    assign protocol_error_out = st.err;
    assign cf_active_out = st.cf_active;
    assign frame_seen_out = st.seen;
endmodule

// File: sim/mac_medium_monitor.sv
`timescale 1ns/10ps
module mac_medium_monitor (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic coord_valid,
    input wire mac_seq_pkg::frame_t coord_frame,
    input wire logic sta_valid,
    input wire mac_seq_pkg::frame_t sta_frame
);
    logic [7:0] idle;
    logic owed;

    // idle count starts saturated so the first frame after reset opens a sequence
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idle <= 8'hFF;
            owed <= 1'b0;
        end else if (coord_valid || sta_valid) begin
            idle <= 8'h00;
            owed <= sta_valid && !sta_frame.addr1_group && (sta_frame.kind inside
                {mac_seq_pkg::K_DATA, mac_seq_pkg::K_DATA_CFACK, mac_seq_pkg::K_MGMT});
        end else if (idle != 8'hFF) begin
            idle <= idle + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    // replies land 17 edges after the frame: one pulse plus the 16-cycle gap
    a_no_collision: assert property (!(coord_valid && sta_valid))
        else $error("both ends sent a frame at once");
    a_reply_gap_exact: assert property (sta_valid |-> idle == mac_seq_pkg::GAP_SIFS)
        else $error("station reply not one gap after the frame");
    a_coord_gap_min: assert property (coord_valid |-> idle >= mac_seq_pkg::GAP_SIFS)
        else $error("coordinator frame inside the gap");
    a_data_acked: assert property (coord_valid && !coord_frame.addr1_group &&
        (coord_frame.kind inside {mac_seq_pkg::K_DATA, mac_seq_pkg::K_DATA_CFACK})
        |-> ##17 sta_valid && sta_frame.kind == mac_seq_pkg::K_ACK)
        else $error("directed data not acknowledged");
    a_mgmt_acked: assert property (coord_valid && !coord_frame.da_group &&
        coord_frame.kind == mac_seq_pkg::K_MGMT
        |-> ##17 sta_valid && sta_frame.kind == mac_seq_pkg::K_ACK)
        else $error("directed management not acknowledged");
    a_group_silent: assert property (coord_valid &&
        ((coord_frame.kind == mac_seq_pkg::K_DATA && coord_frame.addr1_group) ||
        (coord_frame.kind == mac_seq_pkg::K_MGMT && coord_frame.da_group))
        |-> ##17 !sta_valid)
        else $error("group frame was answered");
    a_rts_cts: assert property (coord_valid && coord_frame.kind == mac_seq_pkg::K_RTS
        |-> ##17 sta_valid && sta_frame.kind == mac_seq_pkg::K_CTS)
        else $error("request to send not cleared");
    a_poll_reply: assert property (coord_valid && !coord_frame.addr1_group &&
        (coord_frame.kind inside {mac_seq_pkg::K_DATA_POLL, mac_seq_pkg::K_DATA_POLL_ACK})
        |-> ##17 sta_valid && (sta_frame.kind inside
        {mac_seq_pkg::K_DATA_CFACK, mac_seq_pkg::K_CFACK, mac_seq_pkg::K_ACK}))
        else $error("data poll answered wrongly");
    a_bare_poll: assert property (coord_valid &&
        (coord_frame.kind inside {mac_seq_pkg::K_POLL, mac_seq_pkg::K_POLL_ACK})
        |-> ##17 sta_valid && (sta_frame.kind inside {mac_seq_pkg::K_DATA, mac_seq_pkg::K_NULL}))
        else $error("bare poll answered wrongly");
    a_end_variant: assert property (coord_valid &&
        (coord_frame.kind inside {mac_seq_pkg::K_CFEND, mac_seq_pkg::K_CFEND_ACK})
        |-> coord_frame.addr1_group && ((coord_frame.kind == mac_seq_pkg::K_CFEND_ACK) == owed))
        else $error("wrong end frame variant");

    c_data_poll: cover property (coord_valid && coord_frame.kind == mac_seq_pkg::K_DATA_POLL);
    c_null: cover property (sta_valid && sta_frame.kind == mac_seq_pkg::K_NULL);
    c_end_ack: cover property (coord_valid && coord_frame.kind == mac_seq_pkg::K_CFEND_ACK);
endmodule

// File: sim/tb.sv
`timescale 1ns/10ps
module tb;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic tx_valid_in = 1'b0;
    mac_seq_pkg::frame_t tx_frame_in = mac_seq_pkg::FRAME_RESET;
    logic cf_end_req_in = 1'b0;
    logic queue_nonempty_in = 1'b1;
    logic cf_aware_in = 1'b1;
    logic tx_ready_out, cf_end_ready_out, protocol_error_out, coord_cf, sta_cf, data_taken_out;
    int num_errors = 0;
    int checked = 0;
    int errs = 0;
    int cycles = 0;

    mac_medium_if med (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in));
    mac_coord_end mac_coord_end_inst (.med(med), .tx_valid_in(tx_valid_in),
        .tx_frame_in(tx_frame_in), .tx_ready_out(tx_ready_out), .cf_end_req_in(cf_end_req_in),
        .cf_end_ready_out(cf_end_ready_out), .protocol_error_out(protocol_error_out),
        .cf_active_out(coord_cf), .frame_seen_out());
    mac_station_end mac_station_end_inst (.med(med), .queue_nonempty_in(queue_nonempty_in),
        .cf_aware_in(cf_aware_in), .data_taken_out(data_taken_out), .cf_active_out(sta_cf));
    mac_medium_monitor mac_medium_monitor_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .coord_valid(med.coord_valid), .coord_frame(med.coord_frame),
        .sta_valid(med.sta_valid), .sta_frame(med.sta_frame));

    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    // error pulses last one cycle, so tally them at every falling edge
    always @(negedge ref_clk_in) begin
        if (protocol_error_out === 1'b1) errs++;
    end

    // a hang is cut short well past the thousand or so cycles the run needs
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_kind(input mac_seq_pkg::frame_kind_t got, input mac_seq_pkg::frame_kind_t exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t kind %s, expected %s", $time, got.name(), exp.name());
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t flag %b, expected %b", $time, got, exp);
        end
    endtask

    // user request or end request, held until accepted, then the frame is awaited
    task automatic tx(input bit fin, input mac_seq_pkg::frame_kind_t k, input logic a1,
                      input logic da, input logic nz);
        int n;
        @(negedge ref_clk_in);
        if (fin) cf_end_req_in = 1'b1;
        else begin
            tx_valid_in = 1'b1;
            tx_frame_in = '{kind: k, addr1_group: a1, da_group: da, cf_dur_nz: nz};
        end
        n = 0;
        do @(posedge ref_clk_in); while (((fin ? cf_end_ready_out : tx_ready_out) !== 1'b1)
                                         && ++n < 50);
        @(negedge ref_clk_in);
        tx_valid_in = 1'b0;
        cf_end_req_in = 1'b0;
        n = 0;
        while (med.coord_valid !== 1'b1 && n < 40) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk_kind(med.coord_frame.kind, k);
    endtask

    task automatic reply(input logic want, input mac_seq_pkg::frame_kind_t k);
        int n;
        n = 0;
        while (med.sta_valid !== 1'b1 && n < 30) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk_bit(med.sta_valid, want);
        if (want) begin
            chk_kind(med.sta_frame.kind, k);
            chk_bit(data_taken_out, logic'(k inside {mac_seq_pkg::K_DATA, mac_seq_pkg::K_DATA_CFACK}));
        end
    endtask

    // a long idle ends any open sequence before the next one starts
    task automatic gap();
        repeat (25) @(negedge ref_clk_in);
    endtask

    initial begin
        repeat (12) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        tx(0, mac_seq_pkg::K_DATA, 0, 1, 0);
        reply(1, mac_seq_pkg::K_ACK);
        gap();
        tx(0, mac_seq_pkg::K_RTS, 0, 0, 0);
        reply(1, mac_seq_pkg::K_CTS);
        repeat (2) begin
            tx(0, mac_seq_pkg::K_DATA, 0, 0, 0);
            reply(1, mac_seq_pkg::K_ACK);
        end
        gap();
        tx(0, mac_seq_pkg::K_MGMT, 1, 0, 0);
        reply(1, mac_seq_pkg::K_ACK);
        gap();
        tx(0, mac_seq_pkg::K_MGMT, 0, 1, 0);
        reply(0, mac_seq_pkg::K_ACK);
        gap();
        tx(0, mac_seq_pkg::K_PSPOLL, 0, 0, 0);
        tx(0, mac_seq_pkg::K_ACK, 0, 0, 0);
        gap();
        tx(0, mac_seq_pkg::K_PSPOLL, 0, 0, 0);
        tx(0, mac_seq_pkg::K_DATA, 0, 0, 0);
        reply(1, mac_seq_pkg::K_ACK);
        repeat (3) @(negedge ref_clk_in);
        chk_bit(logic'(errs == 0), 1'b1);
        $display("contention sequences done");
        gap();
        // eleven group frames back to back: the last one overruns the run
        repeat (11) tx(0, mac_seq_pkg::K_DATA, 1, 1, 0);
        repeat (3) @(negedge ref_clk_in);
        chk_bit(logic'(errs == 1), 1'b1);
        $display("group run done");
        gap();
        tx(0, mac_seq_pkg::K_BEACON, 1, 1, 0);
        repeat (3) @(negedge ref_clk_in);
        chk_bit(coord_cf | sta_cf, 1'b0);
        gap();
        tx(0, mac_seq_pkg::K_BEACON, 1, 1, 1);
        repeat (3) @(negedge ref_clk_in);
        chk_bit(coord_cf & sta_cf, 1'b1);
        tx(0, mac_seq_pkg::K_DATA_POLL, 0, 0, 0);
        reply(1, mac_seq_pkg::K_DATA_CFACK);
        gap();
        tx(1, mac_seq_pkg::K_CFEND_ACK, 1, 1, 0);
        repeat (3) @(negedge ref_clk_in);
        chk_bit(coord_cf | sta_cf, 1'b0);
        gap();
        tx(0, mac_seq_pkg::K_BEACON, 1, 1, 1);
        queue_nonempty_in = 1'b0;
        tx(0, mac_seq_pkg::K_DATA_POLL_ACK, 0, 0, 0);
        reply(1, mac_seq_pkg::K_CFACK);
        gap();
        cf_aware_in = 1'b0;
        tx(0, mac_seq_pkg::K_DATA, 0, 0, 0);
        reply(1, mac_seq_pkg::K_ACK);
        tx(0, mac_seq_pkg::K_DATA_POLL, 0, 0, 0);
        reply(1, mac_seq_pkg::K_ACK);
        gap();
        cf_aware_in = 1'b1;
        queue_nonempty_in = 1'b1;
        tx(0, mac_seq_pkg::K_POLL, 0, 0, 0);
        reply(1, mac_seq_pkg::K_DATA);
        gap();
        queue_nonempty_in = 1'b0;
        tx(0, mac_seq_pkg::K_POLL_ACK, 0, 0, 0);
        reply(1, mac_seq_pkg::K_NULL);
        tx(0, mac_seq_pkg::K_CFACK, 0, 0, 0);
        tx(0, mac_seq_pkg::K_MGMT, 0, 1, 0);
        reply(0, mac_seq_pkg::K_ACK);
        gap();
        tx(1, mac_seq_pkg::K_CFEND, 1, 1, 0);
        repeat (3) @(negedge ref_clk_in);
        chk_bit(logic'(errs == 1), 1'b1);
        $display("free period done");
        end_of_test();
    end
endmodule
